// *** di_irq_pkg.sv ***
// constants, types and record layouts of the edge interrupt and diagnostics block
package di_irq_pkg;

	// ==========================================================
	// timing
	localparam int              CLK_PERIOD_NS = 40;
	localparam int              US_NS         = 1000;
	localparam int              US_CYCLES     = US_NS / CLK_PERIOD_NS;
	localparam logic [4:0]      US_LAST       = 5'(US_CYCLES - 1);
	localparam int              CHANNELS      = 4;

	// ==========================================================
	// field positions and fixed record values
	localparam int              SUM_MODULE    = 0;
	localparam int              SUM_EXTERNAL  = 2;
	localparam int              SUM_CHANNEL   = 3;
	localparam int              INT_OVERFLOW  = 3;
	localparam int              INT_IRQ_LOST  = 6;
	localparam logic [7:0]      MODULE_INFO   = 8'h1f;
	localparam logic [7:0]      CHANNEL_KIND  = 8'h70;
	localparam logic [7:0]      BITS_PER_CH   = 8'h00;
	localparam logic [7:0]      CHANNEL_COUNT = 8'h04;
	localparam logic [7:0]      DIAG_IRQ_ENABLE_ON    = 8'h40;
	localparam logic [7:0]      PARAM_RESET   = 8'h00;
	localparam logic [7:0]      BYTE_ZERO     = 8'h00;

	// ==========================================================
	// byte offsets inside the records
	localparam logic [4:0]      DIAG_SUMMARY  = 5'h00;
	localparam logic [4:0]      DIAG_INFO     = 5'h01;
	localparam logic [4:0]      DIAG_RSVD     = 5'h02;
	localparam logic [4:0]      DIAG_INTERNAL = 5'h03;
	localparam logic [4:0]      DIAG_KIND     = 5'h04;
	localparam logic [4:0]      DIAG_DIAG_BITS_PER_CHANNEL   = 5'h05;
	localparam logic [4:0]      DIAG_CHANNEL_COUNT    = 5'h06;
	localparam logic [4:0]      DIAG_EDGE_LOST_FLAGS    = 5'h07;
	localparam logic [4:0]      DIAG_TS0      = 5'h10;
	localparam logic [4:0]      DIAG_TS1      = 5'h11;
	localparam logic [4:0]      DIAG_TS2      = 5'h12;
	localparam logic [4:0]      DIAG_TS3      = 5'h13;
	localparam logic [4:0]      PROC_FLAGS    = 5'h00;
	localparam logic [4:0]      PROC_SNAP     = 5'h01;
	localparam logic [4:0]      PROC_TS0      = 5'h02;
	localparam logic [4:0]      PROC_TS1      = 5'h03;
	localparam logic [1:0]      SEL_DIAG_IRQ_ENABLE   = 2'h0;
	localparam logic [1:0]      SEL_RISE      = 2'h1;
	localparam logic [1:0]      SEL_FALL      = 2'h2;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		REC_DIAG  = 2'h0,
		REC_PROC  = 2'h1,
		REC_PARAM = 2'h2
	} rec_sel_e;

	typedef enum logic [1:0] {
		DG_IDLE     = 2'b00,
		DG_INCOMING = 2'b01,
		DG_ACTIVE   = 2'b11,
		DG_GOING    = 2'b10
	} diag_state_e;

	typedef struct packed {
		logic       valid;
		logic [1:0] sel;
		logic [7:0] data;
	} param_wr_s;

	typedef struct packed {
		logic [15:0] ts;
		logic [3:0]  snap;
		logic [3:0]  flags;
	} proc_rec_s;

endpackage

// *** di_edge_interrupt_diagnostics.sv ***
// edge process interrupts, diagnostic record and microsecond ticker of a four channel input module
`timescale 1ns/1ps

//
// Contract
// RQ1 - rising edge mask byte, bits 0..3 enable channel low-to-high interrupts
// RQ2 - falling edge mask byte, bits 0..3 enable channel high-to-low interrupts
// RQ3 - enabled edge raises a process interrupt, never a diagnostic one
// RQ4 - process record byte 0 flags channels that produced the edge
// RQ5 - process record byte 1 holds input levels at interrupt time
// RQ6 - process record ends with low 16 ticker bits latched at interrupt
// RQ7 - 32-bit microsecond ticker from zero at reset, wrapping at maximum
// RQ8 - process data goes out as a message record, host reads it
// RQ9 - diagnostic interrupt only when enabled by parameter
// RQ10 - new diagnostic cause issues incoming interrupt with its record
// RQ11 - going interrupt issued by itself once all causes cleared
// RQ12 - channel events between incoming and going are discarded
// RQ13 - fault indicator on from first incoming to last going
// RQ14 - host reads full record by set 01h, first four by 00h
// RQ15 - fieldbus host reads full record at 2F01h, first four at 2F00h
// RQ16 - diag byte 0: bit0 module failure, bit2 external, bit3 channel
// RQ17 - module info byte: class 1111b digital, bit4 channel info present
// RQ18 - channel error byte bits 0..3 mark lost edges per channel
// RQ19 - diag byte 3 bit 3 on buffer overflow, raising diagnostics
// RQ20 - diag byte 3 bit 6 on lost process interrupt, raising diagnostics
// RQ21 - diag record timestamp holds full ticker latched at diagnostic event
// RQ22 - reserved bits and bytes of all records read as zero
module di_edge_interrupt_diagnostics (
	input  wire logic                  clock,
	input  wire logic                  resetn,
	input  wire logic [3:0]            input_channel,
	input  wire logic                  external_fault,
	input  wire di_irq_pkg::param_wr_s param_wr,
	input  wire logic                  proc_ack,
	input  wire logic                  diag_ack,
	input  wire di_irq_pkg::rec_sel_e  rec_sel,
	input  wire logic [4:0]            rec_byte,
	output logic                       proc_irq_req,
	output di_irq_pkg::proc_rec_s      proc_record,
	output logic                       diag_irq_req,
	output logic                       diag_irq_going,
	output logic                       module_fault_indicator,
	output logic [7:0]                 rec_data
);

	// ==========================================================
	// helpers
	function automatic logic [3:0] edge_hits(input logic [3:0] cur, input logic [3:0] prev,
		input logic [3:0] mask, input logic rising);
		return rising ? (cur & ~prev & mask) : (~cur & prev & mask);
	endfunction

	// ==========================================================
	// microsecond ticker
	logic [4:0]  pre_q, pre_d;
	logic [31:0] tick_q, tick_d;

	// RQ7 prescale and wrap
	always_comb begin
		pre_d  = pre_q + 5'h01;
		tick_d = tick_q;
		if (pre_q == di_irq_pkg::US_LAST) begin
			pre_d  = 5'h00;
			tick_d = tick_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pre_q  <= 5'h00;
			tick_q <= 32'h0000_0000;
		end else begin
			pre_q  <= pre_d;
			tick_q <= tick_d;
		end
	end

	// ==========================================================
	// parameters
	logic [7:0] diag_irq_enable_q, diag_irq_enable_d;
	logic [3:0] rise_mask_q, rise_mask_d;
	logic [3:0] fall_mask_q, fall_mask_d;
	logic       diag_enabled;

	// RQ1 RQ2 reserved mask bits are dropped on write
	always_comb begin
		diag_irq_enable_d   = diag_irq_enable_q;
		rise_mask_d = rise_mask_q;
		fall_mask_d = fall_mask_q;
		if (param_wr.valid) begin
			case (param_wr.sel)
				di_irq_pkg::SEL_DIAG_IRQ_ENABLE: begin
					diag_irq_enable_d = param_wr.data;
				end
				di_irq_pkg::SEL_RISE: begin
					rise_mask_d = param_wr.data[3:0];
				end
				di_irq_pkg::SEL_FALL: begin
					fall_mask_d = param_wr.data[3:0];
				end
				default: begin
					diag_irq_enable_d = diag_irq_enable_q;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			diag_irq_enable_q   <= di_irq_pkg::PARAM_RESET;
			rise_mask_q <= di_irq_pkg::PARAM_RESET[3:0];
			fall_mask_q <= di_irq_pkg::PARAM_RESET[3:0];
		end else begin
			diag_irq_enable_q   <= diag_irq_enable_d;
			rise_mask_q <= rise_mask_d;
			fall_mask_q <= fall_mask_d;
		end
	end

	// RQ9 only the documented enable code switches diagnostics on
	assign diag_enabled = (diag_irq_enable_q == di_irq_pkg::DIAG_IRQ_ENABLE_ON);

	// ==========================================================
	// process interrupt
	logic [3:0]            prev_q, prev_d;
	logic                  prev_ok_q, prev_ok_d;
	logic                  pend_q, pend_d;
	di_irq_pkg::proc_rec_s rec_q, rec_d;
	logic [3:0]            lost_q, lost_d;
	logic                  irq_lost_q, irq_lost_d;
	logic                  window;
	logic                  diag_clear;
	logic [3:0]            events;
	logic                  accept;
	logic                  drop;

	// first cycle after reset only primes the edge history
	assign events = prev_ok_q ? (edge_hits(input_channel, prev_q, rise_mask_q, 1'b1)
		| edge_hits(input_channel, prev_q, fall_mask_q, 1'b0)) : 4'h0;
	// RQ12 events inside the diagnostic window are thrown away
	assign accept = (|events) && !window && (!pend_q || proc_ack);
	assign drop   = (|events) && !window && pend_q && !proc_ack;

	// RQ3 RQ4 RQ5 RQ6 capture a new record, set wins over ack
	always_comb begin
		prev_d     = input_channel;
		prev_ok_d  = 1'b1;
		pend_d     = pend_q && !proc_ack;
		rec_d      = rec_q;
		lost_d     = diag_clear ? 4'h0 : lost_q;
		irq_lost_d = irq_lost_q && !diag_clear;
		if (accept) begin
			pend_d     = 1'b1;
			rec_d.flags = events;
			rec_d.snap  = input_channel;
			rec_d.ts    = tick_q[15:0];
		end
		// RQ18 RQ20 previous record still unread, the edge is lost
		if (drop) begin
			lost_d     = lost_d | events;
			irq_lost_d = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			prev_q     <= 4'h0;
			prev_ok_q  <= 1'b0;
			pend_q     <= 1'b0;
			rec_q      <= '0;
			lost_q     <= 4'h0;
			irq_lost_q <= 1'b0;
		end else begin
			prev_q     <= prev_d;
			prev_ok_q  <= prev_ok_d;
			pend_q     <= pend_d;
			rec_q      <= rec_d;
			lost_q     <= lost_d;
			irq_lost_q <= irq_lost_d;
		end
	end

	assign proc_irq_req = pend_q;
	assign proc_record  = rec_q;

	// ==========================================================
	// diagnostics
	di_irq_pkg::diag_state_e state_q, state_d;
	logic [31:0]             dts_q, dts_d;
	logic                    ovf_q, ovf_d;
	logic                    ext_prev_q;
	logic                    cause;
	logic [7:0]              summary;
	logic [7:0]              internal;

	// RQ16 summary bits 0 and 3 follow the sticky causes, bit 2 the live external fault input
	always_comb begin
		summary = di_irq_pkg::BYTE_ZERO;
		summary[di_irq_pkg::SUM_MODULE]   = ovf_q || irq_lost_q;
		summary[di_irq_pkg::SUM_EXTERNAL] = external_fault;
		summary[di_irq_pkg::SUM_CHANNEL]  = |lost_q;
		internal = di_irq_pkg::BYTE_ZERO;
		internal[di_irq_pkg::INT_OVERFLOW] = ovf_q;
		internal[di_irq_pkg::INT_IRQ_LOST] = irq_lost_q;
	end

	// RQ19 RQ20 overflow and lost interrupt are causes in their own right
	assign cause      = external_fault || ovf_q || irq_lost_q || (|lost_q);
	assign diag_clear = diag_ack && ((state_q == di_irq_pkg::DG_INCOMING) || !diag_enabled);
	assign window     = (state_q != di_irq_pkg::DG_IDLE);

	// RQ10 RQ11 incoming, wait for the causes to go, then going by itself
	always_comb begin
		state_d = state_q;
		dts_d   = dts_q;
		ovf_d   = ovf_q && !diag_clear;
		// RQ19 a new rising edge of external_fault while a notice is still unread overflows the buffer
		if (external_fault && !ext_prev_q && diag_irq_req) begin
			ovf_d = 1'b1;
		end
		case (state_q)
			di_irq_pkg::DG_IDLE: begin
				// RQ9 RQ21 enter only when enabled, stamp the full ticker
				if (diag_enabled && cause) begin
					state_d = di_irq_pkg::DG_INCOMING;
					dts_d   = tick_q;
				end
			end
			di_irq_pkg::DG_INCOMING: begin
				if (diag_ack) begin
					state_d = di_irq_pkg::DG_ACTIVE;
				end
			end
			di_irq_pkg::DG_ACTIVE: begin
				if (!cause) begin
					state_d = di_irq_pkg::DG_GOING;
				end
			end
			di_irq_pkg::DG_GOING: begin
				if (diag_ack) begin
					state_d = di_irq_pkg::DG_IDLE;
				end
			end
			default: begin
				state_d = di_irq_pkg::DG_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_q    <= di_irq_pkg::DG_IDLE;
			dts_q      <= 32'h0000_0000;
			ovf_q      <= 1'b0;
			ext_prev_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			dts_q      <= dts_d;
			ovf_q      <= ovf_d;
			ext_prev_q <= external_fault;
		end
	end

	assign diag_irq_req   = (state_q == di_irq_pkg::DG_INCOMING) || (state_q == di_irq_pkg::DG_GOING);
	assign diag_irq_going = (state_q == di_irq_pkg::DG_GOING);
	// RQ13 indicator spans the whole window
	assign module_fault_indicator = window;

	// ==========================================================
	// record read port
	logic [7:0] rd_d, rd_q;

	// RQ8 RQ17 RQ22 byte mux, unlisted and reserved bytes read zero
	always_comb begin
		rd_d = di_irq_pkg::BYTE_ZERO;
		case (rec_sel)
			di_irq_pkg::REC_DIAG: begin
				case (rec_byte)
					di_irq_pkg::DIAG_SUMMARY:  rd_d = summary;
					di_irq_pkg::DIAG_INFO:     rd_d = di_irq_pkg::MODULE_INFO;
					di_irq_pkg::DIAG_INTERNAL: rd_d = internal;
					di_irq_pkg::DIAG_KIND:     rd_d = di_irq_pkg::CHANNEL_KIND;
					di_irq_pkg::DIAG_DIAG_BITS_PER_CHANNEL:   rd_d = di_irq_pkg::BITS_PER_CH;
					di_irq_pkg::DIAG_CHANNEL_COUNT:    rd_d = di_irq_pkg::CHANNEL_COUNT;
					di_irq_pkg::DIAG_EDGE_LOST_FLAGS:    rd_d = {4'h0, lost_q};
					di_irq_pkg::DIAG_TS0:      rd_d = dts_q[7:0];
					di_irq_pkg::DIAG_TS1:      rd_d = dts_q[15:8];
					di_irq_pkg::DIAG_TS2:      rd_d = dts_q[23:16];
					di_irq_pkg::DIAG_TS3:      rd_d = dts_q[31:24];
					default:                   rd_d = di_irq_pkg::BYTE_ZERO;
				endcase
			end
			di_irq_pkg::REC_PROC: begin
				case (rec_byte)
					di_irq_pkg::PROC_FLAGS: rd_d = {4'h0, rec_q.flags};
					di_irq_pkg::PROC_SNAP:  rd_d = {4'h0, rec_q.snap};
					di_irq_pkg::PROC_TS0:   rd_d = rec_q.ts[7:0];
					di_irq_pkg::PROC_TS1:   rd_d = rec_q.ts[15:8];
					default:                rd_d = di_irq_pkg::BYTE_ZERO;
				endcase
			end
			di_irq_pkg::REC_PARAM: begin
				case (rec_byte)
					5'(di_irq_pkg::SEL_DIAG_IRQ_ENABLE): rd_d = diag_irq_enable_q;
					5'(di_irq_pkg::SEL_RISE):    rd_d = {4'h0, rise_mask_q};
					5'(di_irq_pkg::SEL_FALL):    rd_d = {4'h0, fall_mask_q};
					default:                     rd_d = di_irq_pkg::BYTE_ZERO;
				endcase
			end
			default: begin
				rd_d = di_irq_pkg::BYTE_ZERO;
			end
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rd_q <= di_irq_pkg::BYTE_ZERO;
		end else begin
			rd_q <= rd_d;
		end
	end

	assign rec_data = rd_q;

	// ==========================================================
	// checks
	chk_rise_raise: assert property (@(posedge clock) disable iff (!resetn) // RQ1
		(prev_ok_q && !window && !pend_q && ((input_channel & ~prev_q & rise_mask_q) != 4'h0))
		|=> (proc_irq_req && ((proc_record.flags & $past(rise_mask_q)) != 4'h0)))
		else $error("enabled rising edge gave no process interrupt");
	chk_fall_raise: assert property (@(posedge clock) disable iff (!resetn) // RQ2
		(prev_ok_q && !window && !pend_q && ((~input_channel & prev_q & fall_mask_q) != 4'h0))
		|=> proc_irq_req)
		else $error("enabled falling edge gave no process interrupt");
	chk_edge_not_diag: assert property (@(posedge clock) disable iff (!resetn) // RQ3
		(accept && state_q == di_irq_pkg::DG_IDLE && !cause) |=> !diag_irq_req)
		else $error("edge raised a diagnostic interrupt");
	chk_flags_snap: assert property (@(posedge clock) disable iff (!resetn) // RQ5
		accept |=> (proc_record.snap == $past(input_channel) && proc_record.flags == $past(events)))
		else $error("process record flags or snapshot wrong");
	chk_proc_stamp: assert property (@(posedge clock) disable iff (!resetn) // RQ6
		accept |=> proc_record.ts == $past(tick_q[15:0]))
		else $error("process timestamp not latched");
	chk_tick_step: assert property (@(posedge clock) disable iff (!resetn) // RQ7
		(pre_q == di_irq_pkg::US_LAST) |=> (tick_q == $past(tick_q) + 32'h0000_0001) ##1 $stable(tick_q))
		else $error("ticker did not step once per microsecond");
	chk_diag_gate: assert property (@(posedge clock) disable iff (!resetn) // RQ9
		(!diag_enabled && state_q == di_irq_pkg::DG_IDLE) |=> !diag_irq_req)
		else $error("diagnostic interrupt while disabled");
	chk_incoming: assert property (@(posedge clock) disable iff (!resetn) // RQ10
		(state_q == di_irq_pkg::DG_IDLE && diag_enabled && cause) |=> (diag_irq_req && !diag_irq_going))
		else $error("cause gave no incoming interrupt");
	chk_going_auto: assert property (@(posedge clock) disable iff (!resetn) // RQ11
		(state_q == di_irq_pkg::DG_ACTIVE && !cause) |=> (diag_irq_req && diag_irq_going))
		else $error("no automatic going interrupt");
	chk_window_drop: assert property (@(posedge clock) disable iff (!resetn) // RQ12
		(window && !proc_ack && !diag_clear) |=> ($stable(proc_record) && $stable(lost_q)))
		else $error("channel event stored inside diagnostic window");
	chk_fault_led: assert property (@(posedge clock) disable iff (!resetn) // RQ13
		$rose(diag_irq_req) && !diag_irq_going |-> module_fault_indicator throughout
		(state_q != di_irq_pkg::DG_IDLE))
		else $error("fault indicator off inside window");
	chk_lost_edge: assert property (@(posedge clock) disable iff (!resetn) // RQ18
		drop |=> (((lost_q & $past(events)) == $past(events)) && irq_lost_q && proc_record == $past(rec_q)))
		else $error("lost edge not flagged");
	chk_summary: assert property (@(posedge clock) disable iff (!resetn) // RQ16
		(rec_sel == di_irq_pkg::REC_DIAG && rec_byte == di_irq_pkg::DIAG_SUMMARY)
		|=> (rec_data[7:4] == 4'h0 && !rec_data[1] && rec_data[3] == $past(|lost_q)))
		else $error("summary byte wrong");
	chk_info_byte: assert property (@(posedge clock) disable iff (!resetn) // RQ17
		(rec_sel == di_irq_pkg::REC_DIAG && rec_byte == di_irq_pkg::DIAG_INFO) |=> rec_data == di_irq_pkg::MODULE_INFO)
		else $error("module info byte wrong");
	chk_overflow: assert property (@(posedge clock) disable iff (!resetn) // RQ19
		($rose(external_fault) && diag_irq_req && !diag_clear) |=> ovf_q)
		else $error("overflow not flagged");
	chk_diag_stamp: assert property (@(posedge clock) disable iff (!resetn) // RQ21
		(state_q == di_irq_pkg::DG_IDLE && diag_enabled && cause) |=> dts_q == $past(tick_q))
		else $error("diagnostic timestamp not latched");
	chk_rsvd_zero: assert property (@(posedge clock) disable iff (!resetn) // RQ22
		(rec_sel == di_irq_pkg::REC_PROC && rec_byte == di_irq_pkg::PROC_FLAGS) |=> rec_data[7:4] == 4'h0)
		else $error("reserved bits not zero");

endmodule

// *** host_model.sv ***
// host side model that acknowledges process and diagnostic notices
`timescale 1ns/1ps
module host_model (
	input  wire logic       clock,
	input  wire logic       resetn,
	input  wire logic       enable,
	input  wire logic [1:0] delay,
	input  wire logic       proc_irq_req,
	input  wire logic       diag_irq_req,
	output logic            proc_ack,
	output logic            diag_ack
);
	// ==========================================================
	// acknowledge after a programmable wait
	logic [1:0] proc_wait;
	logic [1:0] diag_wait;

	initial begin
		proc_ack = 1'b0;
		diag_ack = 1'b0;
		proc_wait = 2'h0;
		diag_wait = 2'h0;
	end

	// acks are one cycle pulses driven off the sampling edge
	always @(negedge clock) begin
		proc_ack <= 1'b0;
		diag_ack <= 1'b0;
		if (!resetn || !enable) begin
			proc_wait <= 2'h0;
			diag_wait <= 2'h0;
		end else begin
			if (proc_irq_req === 1'b1 && !proc_ack) begin
				proc_ack <= (proc_wait == delay);
				proc_wait <= (proc_wait == delay) ? 2'h0 : proc_wait + 2'h1;
			end
			if (diag_irq_req === 1'b1 && !diag_ack) begin
				diag_ack <= (diag_wait == delay);
				diag_wait <= (diag_wait == delay) ? 2'h0 : diag_wait + 2'h1;
			end
		end
	end
endmodule

// *** testbench.sv ***
// self-checking bench for the edge interrupt and diagnostics block
`timescale 1ns/1ps
module testbench;
	logic                  clock;
	logic                  resetn;
	logic [3:0]            input_channel;
	logic                  external_fault;
	di_irq_pkg::param_wr_s param_wr;
	logic                  proc_ack;
	logic                  diag_ack;
	di_irq_pkg::rec_sel_e  rec_sel;
	logic [4:0]            rec_byte;
	logic                  proc_irq_req;
	di_irq_pkg::proc_rec_s proc_record;
	logic                  diag_irq_req;
	logic                  diag_irq_going;
	logic                  module_fault_indicator;
	logic [7:0]            rec_data;
	logic                  host_en;
	logic [1:0]            host_delay;
	int                    failures;
	int                    n_compared;
	logic [7:0]            d;
	logic [3:0]            rise;
	logic [3:0]            fall;
	logic [3:0]            nxt;
	logic [3:0]            exp;
	logic [15:0]           ts1;
	logic                  seen;

	always #20 clock = ~clock;

	di_edge_interrupt_diagnostics u_dut (.clock(clock), .resetn(resetn), .input_channel(input_channel),
		.external_fault(external_fault), .param_wr(param_wr), .proc_ack(proc_ack), .diag_ack(diag_ack),
		.rec_sel(rec_sel), .rec_byte(rec_byte), .proc_irq_req(proc_irq_req), .proc_record(proc_record),
		.diag_irq_req(diag_irq_req), .diag_irq_going(diag_irq_going),
		.module_fault_indicator(module_fault_indicator), .rec_data(rec_data));

	host_model u_host (.clock(clock), .resetn(resetn), .enable(host_en), .delay(host_delay),
		.proc_irq_req(proc_irq_req), .diag_irq_req(diag_irq_req), .proc_ack(proc_ack), .diag_ack(diag_ack));

	// ==========================================================
	// helpers
	task automatic test_done;
		if (failures == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk_val(input logic [31:0] got, input logic [31:0] want, input string what);
		n_compared++;
		if (got !== want) begin
			failures++;
			$display("unexpected at %0t: %s got %0h want %0h", $time, what, got, want);
		end
	endtask

	task automatic chk_flag(input logic got, input logic want, input string what);
		chk_val({31'h0, got}, {31'h0, want}, what);
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask

	task automatic wr(input logic [1:0] sel, input logic [7:0] v);
		param_wr = '{valid: 1'b1, sel: sel, data: v};
		tick(1);
		param_wr.valid = 1'b0;
		// one idle edge so back to back writes never touch valid twice in one step
		tick(1);
	endtask

	task automatic rd(input logic [1:0] sel, input logic [4:0] idx, output logic [7:0] v);
		rec_sel = di_irq_pkg::rec_sel_e'(sel);
		rec_byte = idx;
		tick(1);
		v = rec_data;
	endtask

	// bounded wait: 0 process request gone, 1 diag request up, 2 fault indicator off
	task automatic await(input int k);
		for (int i = 0; i < 200; i++) begin
			if ((k == 0 && proc_irq_req === 1'b0) || (k == 1 && diag_irq_req === 1'b1) ||
				(k == 2 && module_fault_indicator === 1'b0)) begin
				return;
			end
			if (diag_irq_req === 1'b1 && diag_irq_going === 1'b1) begin
				seen = 1'b1;
			end
			tick(1);
		end
		failures++;
		$display("unexpected at %0t: wait %0d timed out", $time, k);
		test_done();
	endtask

	function automatic logic [3:0] exp_flags(input logic [3:0] old, input logic [3:0] nw,
		input logic [3:0] r, input logic [3:0] f);
		return (r & ~old & nw) | (f & old & ~nw);
	endfunction

	function automatic logic [7:0] idle_diag(input logic [4:0] i);
		case (i)
			5'h01: return 8'h1f;
			5'h04: return 8'h70;
			5'h06: return 8'h04;
			default: return 8'h00;
		endcase
	endfunction

	// ==========================================================
	// main sequence
	initial begin
		clock = 1'b0;
		resetn = 1'b0;
		input_channel = 4'h0;
		external_fault = 1'b0;
		param_wr = '0;
		rec_sel = di_irq_pkg::REC_DIAG;
		rec_byte = 5'h00;
		host_en = 1'b0;
		host_delay = 2'h0;
		failures = 0;
		n_compared = 0;
		seen = 1'b0;
		d = 8'($urandom(8732));
		tick(10);
		resetn = 1'b1;
		tick(2);
		// full record walked by byte index
		for (int i = 0; i < 32; i++) begin
			rd(2'h0, 5'(i), d);
			chk_val(d, idle_diag(5'(i)), "idle diag byte");
		end
		for (int i = 0; i < 4; i++) begin
			rd(2'h1, 5'(i), d);
			chk_val(d, 8'h00, "idle process byte");
			rd(2'h3, 5'(i), d);
			chk_val(d, 8'h00, "unused record");
		end
		// random masks and edges, each notice consumed before the next edge
		host_en = 1'b1;
		for (int n = 0; n < 24; n++) begin
			rise = (n == 0) ? 4'hf : 4'($urandom);
			fall = (n == 0) ? 4'hf : 4'($urandom);
			wr(di_irq_pkg::SEL_RISE, {4'($urandom), rise});
			wr(di_irq_pkg::SEL_FALL, {4'($urandom), fall});
			rd(2'h2, 5'h01, d);
			chk_val(d, {4'h0, rise}, "rise mask");
			rd(2'h2, 5'h02, d);
			chk_val(d, {4'h0, fall}, "fall mask");
			host_delay = 2'($urandom);
			nxt = (n < 2) ? ~input_channel : 4'($urandom);
			exp = exp_flags(input_channel, nxt, rise, fall);
			input_channel = nxt;
			tick(1);
			chk_flag(proc_irq_req, exp != 4'h0, "process request");
			chk_flag(diag_irq_req, 1'b0, "diag request");
			if (exp != 4'h0) begin
				chk_val(proc_record.flags, exp, "edge flags");
				chk_val(proc_record.snap, nxt, "snapshot");
			end
			await(0);
		end
		// two edges exactly ten microseconds apart
		host_delay = 2'h0;
		wr(di_irq_pkg::SEL_RISE, 8'h0f);
		// one of the two toggles is a falling edge, so both masks must be on
		wr(di_irq_pkg::SEL_FALL, 8'h0f);
		input_channel = input_channel ^ 4'h8;
		tick(1);
		ts1 = proc_record.ts;
		tick(249);
		input_channel = input_channel ^ 4'h8;
		tick(1);
		chk_val(16'(proc_record.ts - ts1), 16'h000a, "ticker step");
		await(0);
		// lost edge with diagnostics disabled, then enabled
		host_en = 1'b0;
		wr(di_irq_pkg::SEL_DIAG_IRQ_ENABLE, 8'h00);
		wr(di_irq_pkg::SEL_FALL, 8'h00);
		input_channel = 4'h0;
		tick(2);
		input_channel = 4'h1;
		tick(1);
		input_channel = 4'h3;
		tick(3);
		chk_val(proc_record.flags, 4'h1, "record kept");
		chk_flag(diag_irq_req, 1'b0, "disabled diag");
		chk_flag(module_fault_indicator, 1'b0, "disabled fault");
		rd(2'h1, 5'h01, d);
		chk_val(d, 8'h01, "snapshot byte");
		rd(2'h0, 5'h07, d);
		chk_val(d, 8'h02, "lost edge byte");
		rd(2'h0, 5'h03, d);
		chk_val(d, 8'h40, "lost irq byte");
		rd(2'h0, 5'h00, d);
		chk_val(d, 8'h09, "summary byte");
		wr(di_irq_pkg::SEL_DIAG_IRQ_ENABLE, 8'h40);
		await(1);
		chk_flag(diag_irq_going, 1'b0, "incoming notice");
		chk_flag(module_fault_indicator, 1'b1, "fault on");
		rd(2'h0, 5'h10, d);
		ts1[7:0] = d;
		rd(2'h0, 5'h11, d);
		ts1[15:8] = d;
		chk_flag(16'(ts1 - proc_record.ts) <= 16'h0001, 1'b1, "diag stamp");
		wr(2'h3, 8'h00);
		rd(2'h2, 5'h00, d);
		chk_val(d, 8'h40, "diag enable byte");
		input_channel = 4'h7;
		tick(2);
		rd(2'h0, 5'h07, d);
		chk_val(d, 8'h02, "edge discarded");
		seen = 1'b0;
		host_en = 1'b1;
		await(2);
		chk_flag(seen, 1'b1, "going notice");
		rd(2'h0, 5'h07, d);
		chk_val(d, 8'h00, "lost edges cleared");
		// external fault, with a second rising while the notice waits
		host_en = 1'b0;
		external_fault = 1'b1;
		await(1);
		external_fault = 1'b0;
		tick(1);
		external_fault = 1'b1;
		tick(2);
		rd(2'h0, 5'h03, d);
		chk_val(d, 8'h08, "overflow byte");
		rd(2'h0, 5'h00, d);
		chk_val(d, 8'h05, "fault summary");
		seen = 1'b0;
		host_en = 1'b1;
		tick(5);
		chk_flag(module_fault_indicator, 1'b1, "fault held");
		external_fault = 1'b0;
		await(2);
		chk_flag(seen, 1'b1, "going after clear");
		test_done();
	end
endmodule
